//--- dual_async_serial_regs.sv
// dual serial channel register file with baud-rate generators and channel-one queues
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
// How it works
// - cpu reads every register any time except the channel-one data port in queue mode, which reads zero; writes to the flags and queue flags registers are ignored
// - rewriting same value leaves channel undisturbed
// - tx empty flag cleared only by a data port write, not by a flags write
// - data port: read gives rx, write loads tx
// - channel-one data port only outside queue mode
// - one write configures and enables together
// - divisor is 13 bits at 12:0
// - zero divisor stops baud generator
// - baud rate is clock over 32 times divisor
// - hardware may change receiver wakeup bit
// - config register enables/modes, bit 15 reserved, reset zero
// - channel-one queues at fixed half-word ranges
// - queue control holds enables, size, tx pointer
// - queue flags report overrun, status, rx pointer, pending
// - enable bits dedicate transmit/receive pins
module dual_async_serial_regs (
  input  wire logic        clk_i,              // 125 MHz system clock
  input  wire logic        srst_i,             // synchronous reset, active high
  input  wire logic [15:0] addr_i,             // half-word address, low 16 bits
  input  wire logic [15:0] wdata_i,            // write data
  input  wire logic        wr_i,               // write strobe
  input  wire logic        rd_i,               // read strobe
  output logic      [15:0] rdata_o,            // read data, cycle after rd_i
  input  wire logic [1:0]  wakeup_clr_i,       // channel logic clears wakeup bit
  input  wire logic [1:0]  flags_set_i,        // channel logic raises tx empty
  input  wire logic [15:0] rx1_data_i,         // channel one received word
  input  wire logic [15:0] rx2_data_i,         // channel two received word
  input  wire logic [15:0] queue_status_i,     // queue engine status word
  output logic      [1:0]  baud_tick_o,        // one-cycle pulses at the baud rate, every 32 x divisor clocks
  output logic      [1:0]  tx_pin_owned_o,     // tx pin dedicated to channel
  output logic      [1:0]  rx_pin_owned_o,     // rx pin dedicated to channel
  output logic      [1:0]  tx_load_o,          // data port write pulse
  output logic      [15:0] tx_data_o,          // last loaded transmit word
  output logic      [15:0] chan1_config_o,     // channel one config
  output logic      [15:0] chan2_config_o      // channel two config
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  dual_async_serial_pkg::bus_req_t req;                     // bundled request
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  logic        hit_b1, hit_c1, hit_f1, hit_d1;  // channel one selects
  logic        hit_b2, hit_c2, hit_f2, hit_d2;  // channel two selects
  logic        hit_qc, hit_qf, hit_txq, hit_rxq; // queue selects
  logic        queue_mode;                       // channel one queue active
  logic [3:0]  q_idx;                            // queue word index

  // each register at its own fixed offset
  always_comb begin
    hit_b1  = (req.addr == dual_async_serial_pkg::CHAN1_BAUD_CONTROL_OFS);
    hit_c1  = (req.addr == dual_async_serial_pkg::CHAN1_CONFIG_CONTROL_OFS);
    hit_f1  = (req.addr == dual_async_serial_pkg::CHAN1_FLAGS_OFS);
    hit_d1  = (req.addr == dual_async_serial_pkg::CHAN1_DATA_PORT_OFS);
    hit_b2  = (req.addr == dual_async_serial_pkg::CHAN2_BAUD_CONTROL_OFS);
    hit_c2  = (req.addr == dual_async_serial_pkg::CHAN2_CONFIG_CONTROL_OFS);
    hit_f2  = (req.addr == dual_async_serial_pkg::CHAN2_FLAGS_OFS);
    hit_d2  = (req.addr == dual_async_serial_pkg::CHAN2_DATA_PORT_OFS);
    hit_qc  = (req.addr == dual_async_serial_pkg::QUEUE_CONTROL_OFS);
    hit_qf  = (req.addr == dual_async_serial_pkg::QUEUE_FLAGS_OFS);
    // half-word aligned ranges only
    hit_txq = (req.addr >= dual_async_serial_pkg::TXQ_FIRST_OFS) &&
              (req.addr <= dual_async_serial_pkg::TXQ_LAST_OFS) && !req.addr[0];
    hit_rxq = (req.addr >= dual_async_serial_pkg::RXQ_FIRST_OFS) &&
              (req.addr <= dual_async_serial_pkg::RXQ_LAST_OFS) && !req.addr[0];
    q_idx   = hit_txq ? 4'((req.addr - dual_async_serial_pkg::TXQ_FIRST_OFS) >> 1)
                      : 4'((req.addr - dual_async_serial_pkg::RXQ_FIRST_OFS) >> 1);
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [15:0] chan1_baud_control_ff;    // divisor, channel one
  logic [15:0] chan2_baud_control_ff;    // divisor, channel two
  logic [15:0] chan1_config_control_ff;  // config, channel one
  logic [15:0] chan2_config_control_ff;  // config, channel two
  logic [15:0] queue_control_ff;         // queue control word

  // baud control: reserved bits masked so they always read zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      chan1_baud_control_ff <= dual_async_serial_pkg::CTRL_RESET;
      chan2_baud_control_ff <= dual_async_serial_pkg::CTRL_RESET;
    end else if (req.wr) begin
      if (hit_b1)
        chan1_baud_control_ff <= req.wdata & dual_async_serial_pkg::BAUD_WR_MASK;
      if (hit_b2)
        chan2_baud_control_ff <= req.wdata & dual_async_serial_pkg::BAUD_WR_MASK;
    end
  end

  // config: software write wins over hardware wakeup clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      chan1_config_control_ff <= dual_async_serial_pkg::CTRL_RESET;
      chan2_config_control_ff <= dual_async_serial_pkg::CTRL_RESET;
    end else begin
      if (req.wr && hit_c1)
        chan1_config_control_ff <= req.wdata & dual_async_serial_pkg::CFG_WR_MASK;
      else if (wakeup_clr_i[0])
        chan1_config_control_ff[dual_async_serial_pkg::CFG_RX_WAKEUP_BIT] <= 1'b0;
      if (req.wr && hit_c2)
        chan2_config_control_ff <= req.wdata & dual_async_serial_pkg::CFG_WR_MASK;
      else if (wakeup_clr_i[1])
        chan2_config_control_ff[dual_async_serial_pkg::CFG_RX_WAKEUP_BIT] <= 1'b0;
    end
  end

  // queue control word
  always_ff @(posedge clk_i) begin
    if (srst_i)
      queue_control_ff <= dual_async_serial_pkg::CTRL_RESET;
    else if (req.wr && hit_qc)
      queue_control_ff <= req.wdata;
  end

  assign queue_mode = queue_control_ff[dual_async_serial_pkg::QCTL_TXQ_EN_BIT] |
                      queue_control_ff[dual_async_serial_pkg::QCTL_RXQ_EN_BIT];

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic [15:0] chan1_flags_ff;   // channel one status
  logic [15:0] chan2_flags_ff;   // channel two status
  logic [15:0] queue_flags_ff;   // queue status snapshot

  // set wins over a same-cycle clear so no event is lost
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      chan1_flags_ff <= dual_async_serial_pkg::FLAGS_RESET;
      chan2_flags_ff <= dual_async_serial_pkg::FLAGS_RESET;
    end else begin
      if (req.wr && hit_d1 && !queue_mode)
        chan1_flags_ff[dual_async_serial_pkg::FLG_TX_EMPTY_BIT] <= 1'b0;
      if (flags_set_i[0])
        chan1_flags_ff[dual_async_serial_pkg::FLG_TX_EMPTY_BIT] <= 1'b1;
      if (req.wr && hit_d2)
        chan2_flags_ff[dual_async_serial_pkg::FLG_TX_EMPTY_BIT] <= 1'b0;
      if (flags_set_i[1])
        chan2_flags_ff[dual_async_serial_pkg::FLG_TX_EMPTY_BIT] <= 1'b1;
    end
  end

  // queue status mirrors the queue engine
  always_ff @(posedge clk_i) begin
    if (srst_i)
      queue_flags_ff <= dual_async_serial_pkg::CTRL_RESET;
    else
      queue_flags_ff <= queue_status_i;
  end

  // ----------------------------------------------------------------
  // queue memories, channel one only
  // ----------------------------------------------------------------
  logic [15:0] txq_mem [dual_async_serial_pkg::QUEUE_DEPTH];  // transmit queue words
  logic [15:0] rxq_mem [dual_async_serial_pkg::QUEUE_DEPTH];  // receive queue words

  // no reset on storage: contents undefined until written
  always_ff @(posedge clk_i) begin
    if (req.wr && hit_txq)
      txq_mem[q_idx] <= req.wdata;
    if (req.wr && hit_rxq)
      rxq_mem[q_idx] <= req.wdata;
  end

  // ----------------------------------------------------------------
  // data ports
  // ----------------------------------------------------------------
  logic [15:0] tx_data_ff;  // transmit holding word
  logic [1:0]  tx_load_ff;  // load pulse per channel

  // only a write to the data port loads transmit data
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_data_ff <= dual_async_serial_pkg::CTRL_RESET;
      tx_load_ff <= 2'h0;
    end else begin
      tx_load_ff[0] <= req.wr && hit_d1 && !queue_mode;
      tx_load_ff[1] <= req.wr && hit_d2;
      if (req.wr && ((hit_d1 && !queue_mode) || hit_d2))
        tx_data_ff <= req.wdata;
    end
  end

  assign tx_load_o = tx_load_ff;
  assign tx_data_o = tx_data_ff;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [15:0] nxt_rdata;  // selected read word
  logic [15:0] rdata_ff;   // registered read data

  // unmapped or queue-mode data reads give zero
  always_comb begin
    nxt_rdata = dual_async_serial_pkg::READ_ZERO;
    if (hit_b1)       nxt_rdata = chan1_baud_control_ff;
    else if (hit_c1)  nxt_rdata = chan1_config_control_ff;
    else if (hit_f1)  nxt_rdata = chan1_flags_ff;
    else if (hit_d1)  nxt_rdata = queue_mode ? dual_async_serial_pkg::READ_ZERO : rx1_data_i;
    else if (hit_b2)  nxt_rdata = chan2_baud_control_ff;
    else if (hit_c2)  nxt_rdata = chan2_config_control_ff;
    else if (hit_f2)  nxt_rdata = chan2_flags_ff;
    else if (hit_d2)  nxt_rdata = rx2_data_i;
    else if (hit_qc)  nxt_rdata = queue_control_ff;
    else if (hit_qf)  nxt_rdata = queue_flags_ff;
    else if (hit_txq) nxt_rdata = txq_mem[q_idx];
    else if (hit_rxq) nxt_rdata = rxq_mem[q_idx];
  end

  // read data stands one cycle only
  always_ff @(posedge clk_i) begin
    if (srst_i)
      rdata_ff <= dual_async_serial_pkg::READ_ZERO;
    else
      rdata_ff <= req.rd ? nxt_rdata : dual_async_serial_pkg::READ_ZERO;
  end

  assign rdata_o = rdata_ff;

  // ----------------------------------------------------------------
  // baud-rate generators
  // ----------------------------------------------------------------
  logic [12:0] div_cnt_ff [2];  // divisor counter per channel
  logic [4:0]  sub_cnt_ff [2];  // 32x oversample counter
  logic        tick_ff [2];     // baud tick pulse per channel, one process each
  logic [12:0] divisor [2];     // live divisor

  assign divisor[0] = chan1_baud_control_ff[12:0];
  assign divisor[1] = chan2_baud_control_ff[12:0];

  // counters restart only on reset or a zero divisor, never on a divisor write, so rewrites are harmless
  for (genvar ch = 0; ch < 2; ch++) begin : g_baud
    always_ff @(posedge clk_i) begin
      if (srst_i || divisor[ch] == dual_async_serial_pkg::DIV_ZERO) begin
        div_cnt_ff[ch] <= dual_async_serial_pkg::DIV_ZERO;
        sub_cnt_ff[ch] <= dual_async_serial_pkg::SUB_ZERO;
        tick_ff[ch]    <= 1'b0;
      end else if (div_cnt_ff[ch] >= divisor[ch] - 13'h0001) begin
        div_cnt_ff[ch] <= dual_async_serial_pkg::DIV_ZERO;
        sub_cnt_ff[ch] <= sub_cnt_ff[ch] + 5'h01;
        tick_ff[ch]    <= (sub_cnt_ff[ch] == dual_async_serial_pkg::OVERSAMPLE_M1);
      end else begin
        div_cnt_ff[ch] <= div_cnt_ff[ch] + 13'h0001;
        tick_ff[ch]    <= 1'b0;
      end
    end
  end

  assign baud_tick_o = {tick_ff[1], tick_ff[0]};

  // ----------------------------------------------------------------
  // pin ownership
  // ----------------------------------------------------------------
  dual_async_serial_pkg::chan_ctl_t ctl1, ctl2;  // per-channel control summary

  always_comb begin
    ctl1.tx_en    = chan1_config_control_ff[dual_async_serial_pkg::CFG_TX_EN_BIT];
    ctl1.rx_en    = chan1_config_control_ff[dual_async_serial_pkg::CFG_RX_EN_BIT];
    ctl1.baud_run = (divisor[0] != dual_async_serial_pkg::DIV_ZERO);
    ctl2.tx_en    = chan2_config_control_ff[dual_async_serial_pkg::CFG_TX_EN_BIT];
    ctl2.rx_en    = chan2_config_control_ff[dual_async_serial_pkg::CFG_RX_EN_BIT];
    ctl2.baud_run = (divisor[1] != dual_async_serial_pkg::DIV_ZERO);
  end

  assign tx_pin_owned_o = {ctl2.tx_en, ctl1.tx_en};
  assign rx_pin_owned_o = {ctl2.rx_en, ctl1.rx_en};
  assign chan1_config_o = chan1_config_control_ff;
  assign chan2_config_o = chan2_config_control_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [17:0] gap_cnt_ff;  // cycles since last channel-one tick

  always_ff @(posedge clk_i) begin
    if (srst_i || tick_ff[0] || !ctl1.baud_run)
      gap_cnt_ff <= 18'h00000;
    else
      gap_cnt_ff <= gap_cnt_ff + 18'h00001;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  baud_zero_stop_a: assert property (divisor[0] == dual_async_serial_pkg::DIV_ZERO |=> !tick_ff[0])
    else $error("tick with zero divisor");
  // checks at least 9 clocks between ticks for any divisor, even across a rewrite
  baud_period_a: assert property ($rose(tick_ff[0])
      |=> !tick_ff[0] [*8])
    else $error("baud ticks too close");
  baud_gap_a: assert property (gap_cnt_ff <= 18'((32 * 8191) + 2))
    else $error("baud tick missing");
  baud_mask_a: assert property (req.wr && hit_b1 |=> chan1_baud_control_ff[15:13] == 3'h0)
    else $error("baud reserved bits set");
  cfg_write_a: assert property (req.wr && hit_c1
      |=> chan1_config_control_ff == ($past(req.wdata) & dual_async_serial_pkg::CFG_WR_MASK))
    else $error("config write lost");
  pin_own_a: assert property (req.wr && hit_c1
      |=> tx_pin_owned_o[0] == $past(req.wdata[dual_async_serial_pkg::CFG_TX_EN_BIT]))
    else $error("tx pin ownership wrong");
  read_timing_a: assert property (req.rd && hit_c2 |=> rdata_o == $past(chan2_config_control_ff))
    else $error("read data wrong");
  queue_block_a: assert property (req.wr && hit_d1 && queue_mode |=> !tx_load_o[0])
    else $error("data port used in queue mode");
  data_load_a: assert property (req.wr && hit_d2 |=> tx_load_o[1] && tx_data_o == $past(req.wdata))
    else $error("tx load missing");
  flag_set_a: assert property (flags_set_i[0] |=> chan1_flags_ff[dual_async_serial_pkg::FLG_TX_EMPTY_BIT])
    else $error("flag set lost");
  wake_clr_a: assert property (wakeup_clr_i[1] && !(req.wr && hit_c2)
      |=> !chan2_config_control_ff[dual_async_serial_pkg::CFG_RX_WAKEUP_BIT])
    else $error("wakeup not cleared");

  cfg_en_c:  cover property (req.wr && hit_c1 && req.wdata[3] && req.wdata[2]);
  tick_c:    cover property (tick_ff[1]);
  queue_c:   cover property (req.wr && hit_txq);
  rd_q_c:    cover property (req.rd && hit_rxq);

endmodule : dual_async_serial_regs

//--- dual_async_serial_pkg.sv
// package: register map, field layout and types for the dual serial register block
package dual_async_serial_pkg;

  // ----------------------------------------------------------------
  // register offsets (16-bit half-word addresses, low 16 bits)
  // ----------------------------------------------------------------
  localparam logic [15:0] CHAN1_BAUD_CONTROL_OFS   = 16'hfc08;
  localparam logic [15:0] CHAN1_CONFIG_CONTROL_OFS = 16'hfc0a;
  localparam logic [15:0] CHAN1_FLAGS_OFS          = 16'hfc0c;
  localparam logic [15:0] CHAN1_DATA_PORT_OFS      = 16'hfc0e;
  localparam logic [15:0] CHAN2_BAUD_CONTROL_OFS   = 16'hfc20;
  localparam logic [15:0] CHAN2_CONFIG_CONTROL_OFS = 16'hfc22;
  localparam logic [15:0] CHAN2_FLAGS_OFS          = 16'hfc24;
  localparam logic [15:0] CHAN2_DATA_PORT_OFS      = 16'hfc26;
  localparam logic [15:0] QUEUE_CONTROL_OFS        = 16'hfc28;
  localparam logic [15:0] QUEUE_FLAGS_OFS          = 16'hfc2a;
  localparam logic [15:0] TXQ_FIRST_OFS            = 16'hfc2c;
  localparam logic [15:0] TXQ_LAST_OFS             = 16'hfc4a;
  localparam logic [15:0] RXQ_FIRST_OFS            = 16'hfc4c;
  localparam logic [15:0] RXQ_LAST_OFS             = 16'hfc6a;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int          QUEUE_DEPTH   = 16;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] FLAGS_RESET   = 16'h0180; // tx empty, tx done
  localparam logic [15:0] BAUD_WR_MASK  = 16'h1fff; // divisor only
  localparam logic [15:0] CFG_WR_MASK   = 16'h7fff; // bit 15 reserved
  localparam logic [15:0] READ_ZERO     = 16'h0000;
  localparam logic [12:0] DIV_ZERO      = 13'h0000;
  localparam logic [4:0]  OVERSAMPLE_M1 = 5'h1f;    // 32 sub-ticks per baud
  localparam logic [4:0]  SUB_ZERO      = 5'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_RX_WAKEUP_BIT = 1;
  localparam int CFG_RX_EN_BIT     = 2;
  localparam int CFG_TX_EN_BIT     = 3;
  localparam int FLG_TX_EMPTY_BIT  = 8;
  localparam int QCTL_TXQ_EN_BIT   = 5;
  localparam int QCTL_RXQ_EN_BIT   = 4;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic        tx_en;    // transmit pin dedicated
    logic        rx_en;    // receive pin dedicated
    logic        baud_run; // divisor non-zero
  } chan_ctl_t;

endpackage : dual_async_serial_pkg

//--- serial_far_model.sv
// far-side model: channel logic that answers the register block
`timescale 1ns/100ps
module serial_far_model #(
  parameter int          WAKE_DLY = 8,       // cycles until wakeup is cleared
  parameter logic [15:0] QSTAT    = 16'h0a5c // queue engine status word
) (
  input  wire logic        clk_i,      // system clock
  input  wire logic        srst_i,     // synchronous reset, active high
  input  wire logic [1:0]  tx_load_i,  // data port write pulses
  input  wire logic [15:0] tx_data_i,  // loaded transmit word
  input  wire logic [1:0]  rx_own_i,   // receive pin dedicated
  input  wire logic [1:0]  wake_bit_i, // config wakeup bits
  output logic      [1:0]  wake_clr_o, // wakeup clear pulses
  output logic      [1:0]  flag_set_o, // tx empty set pulses
  output logic      [15:0] rx1_o,      // channel one received word
  output logic      [15:0] rx2_o,      // channel two received word
  output logic      [15:0] qstat_o     // queue status word
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] d1_ff, d2_ff; // transmit-done delay lines
  logic [3:0] cnt_ff [2];   // wakeup timers

  assign qstat_o = QSTAT;

  // transmitter frees its holding word five cycles after a load
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      d1_ff      <= 4'h0;
      d2_ff      <= 4'h0;
      flag_set_o <= 2'h0;
      rx1_o      <= 16'h0000;
      rx2_o      <= 16'h0000;
    end else begin
      d1_ff      <= {d1_ff[2:0], tx_load_i[0]};
      d2_ff      <= {d2_ff[2:0], tx_load_i[1]};
      flag_set_o <= {d2_ff[3], d1_ff[3]};
      // received word is the scrambled echo of the sent one
      if (tx_load_i[0]) rx1_o <= tx_data_i ^ 16'h5a5a;
      if (tx_load_i[1]) rx2_o <= tx_data_i ^ 16'h5a5a;
    end
  end

  // receiver wakes after a fixed quiet time while enabled and asleep
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (srst_i) begin
        cnt_ff[c]     <= 4'h0;
        wake_clr_o[c] <= 1'b0;
      end else begin
        wake_clr_o[c] <= (int'(cnt_ff[c]) == WAKE_DLY - 1);
        cnt_ff[c]     <= (rx_own_i[c] && wake_bit_i[c]) ? cnt_ff[c] + 4'h1 : 4'h0;
      end
    end
  end
endmodule : serial_far_model

//--- dual_async_serial_regs_baud_test.sv
// self-checking bench for the dual serial register block
`timescale 1ns/100ps
module dual_async_serial_regs_baud_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [15:0] QS = 16'h0a5c;  // queue status from the model
  logic        clk_i   = 1'b0;            // 125 MHz clock
  logic        srst_i  = 1'b1;            // synchronous reset
  logic [15:0] addr_i  = 16'h0000;        // bus address
  logic [15:0] wdata_i = 16'h0000;        // bus write data
  logic        wr_i    = 1'b0;            // write strobe
  logic        rd_i    = 1'b0;            // read strobe
  logic [15:0] rdata_o, rx1, rx2, qstat, tx_data_o, cfg1, cfg2, d;
  logic [1:0]  wake_clr, flag_set, baud_tick_o, tx_own, rx_own, tx_load_o;
  int          errors = 0, n_tests = 0, cyc = 0, n;

  dual_async_serial_regs i_dual_async_serial_regs (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wakeup_clr_i(wake_clr),
    .flags_set_i(flag_set), .rx1_data_i(rx1), .rx2_data_i(rx2), .queue_status_i(qstat),
    .baud_tick_o(baud_tick_o), .tx_pin_owned_o(tx_own), .rx_pin_owned_o(rx_own),
    .tx_load_o(tx_load_o), .tx_data_o(tx_data_o), .chan1_config_o(cfg1), .chan2_config_o(cfg2));

  serial_far_model #(.WAKE_DLY(8), .QSTAT(QS)) i_serial_far_model (.clk_i(clk_i),
    .srst_i(srst_i), .tx_load_i(tx_load_o), .tx_data_i(tx_data_o), .rx_own_i(rx_own),
    .wake_bit_i({cfg2[1], cfg1[1]}), .wake_clr_o(wake_clr), .flag_set_o(flag_set),
    .rx1_o(rx1), .rx2_o(rx2), .qstat_o(qstat));

  // clock and hang guard; the run needs under a thousand cycles
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task chkn(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      errors++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : chkn
  task rchk(input logic [15:0] a, input logic [15:0] exp);
    rd(a, d);
    chk16(d, exp);
  endtask : rchk
  // cycles between two ticks of one channel
  task gap(input int ch, output int g);
    int k;
    k = 0;
    while (baud_tick_o[ch] !== 1'b1 && k < 9000) begin
      @(posedge clk_i); #1 k++;
    end
    g = 0;
    do begin
      @(posedge clk_i); #1 g++;
    end while (baud_tick_o[ch] !== 1'b1 && g < 9000);
  endtask : gap
  task end_sim;
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rchk(dual_async_serial_pkg::CHAN1_BAUD_CONTROL_OFS, 16'h0000);
    rchk(dual_async_serial_pkg::CHAN1_CONFIG_CONTROL_OFS, 16'h0000);
    rchk(dual_async_serial_pkg::CHAN2_BAUD_CONTROL_OFS, 16'h0000);
    rchk(dual_async_serial_pkg::CHAN2_CONFIG_CONTROL_OFS, 16'h0000);
    rchk(dual_async_serial_pkg::CHAN1_FLAGS_OFS, 16'h0180);
    rchk(dual_async_serial_pkg::QUEUE_CONTROL_OFS, 16'h0000);
    rchk(dual_async_serial_pkg::QUEUE_FLAGS_OFS, QS);
    rchk(16'hfc10, 16'h0000);
  endtask : t_reset
  // reserved bits, pin dedication and hardware wakeup clearing
  task t_masks;
    wr(dual_async_serial_pkg::CHAN1_BAUD_CONTROL_OFS, 16'hffff);
    rchk(dual_async_serial_pkg::CHAN1_BAUD_CONTROL_OFS, 16'h1fff);
    wr(dual_async_serial_pkg::CHAN1_BAUD_CONTROL_OFS, 16'h0000);
    wr(dual_async_serial_pkg::CHAN2_CONFIG_CONTROL_OFS, 16'hffff);
    #1 chk16({12'h000, tx_own, rx_own}, 16'h000a);
    rchk(dual_async_serial_pkg::CHAN2_CONFIG_CONTROL_OFS, 16'h7fff);
    repeat (12) @(posedge clk_i);
    rchk(dual_async_serial_pkg::CHAN2_CONFIG_CONTROL_OFS, 16'h7ffd);
    wr(dual_async_serial_pkg::CHAN2_CONFIG_CONTROL_OFS, 16'h0000);
    #1 chk16({12'h000, tx_own, rx_own}, 16'h0000);
  endtask : t_masks
  // divisor first, then one write that configures and enables
  task t_enable;
    wr(dual_async_serial_pkg::CHAN1_BAUD_CONTROL_OFS, 16'h0002);
    wr(dual_async_serial_pkg::CHAN1_CONFIG_CONTROL_OFS, 16'h0c0c);
    #1 chk16(cfg1, 16'h0c0c);
    chk16({12'h000, tx_own, rx_own}, 16'h0005);
  endtask : t_enable
  task t_baud;
    gap(0, n);
    chkn(n, 64);
    // same divisor rewritten mid-period keeps the period
    n = 0;
    repeat (5) @(posedge clk_i);
    wr(dual_async_serial_pkg::CHAN1_BAUD_CONTROL_OFS, 16'h0002);
    #1 n = 7;
    while (baud_tick_o[0] !== 1'b1 && n < 500) begin
      @(posedge clk_i); #1 n++;
    end
    chkn(n, 64);
    rchk(dual_async_serial_pkg::CHAN1_BAUD_CONTROL_OFS, 16'h0002);
    wr(dual_async_serial_pkg::CHAN2_BAUD_CONTROL_OFS, 16'h0001);
    gap(1, n);
    chkn(n, 32);
    wr(dual_async_serial_pkg::CHAN1_CONFIG_CONTROL_OFS, 16'h0000);
    wr(dual_async_serial_pkg::CHAN1_BAUD_CONTROL_OFS, 16'h0000);
    repeat (2) @(posedge clk_i);
    n = 0;
    repeat (200) begin
      @(posedge clk_i); #1 n += int'(baud_tick_o[0]);
    end
    chkn(n, 0);
  endtask : t_baud
  task t_data;
    wr(dual_async_serial_pkg::CHAN2_DATA_PORT_OFS, 16'h3c96);
    #1 chk16({15'h0000, tx_load_o[1]}, 16'h0001);
    chk16(tx_data_o, 16'h3c96);
    rd(dual_async_serial_pkg::CHAN2_FLAGS_OFS, d);
    chk16(d & 16'h0100, 16'h0000);
    repeat (8) @(posedge clk_i);
    rd(dual_async_serial_pkg::CHAN2_FLAGS_OFS, d);
    chk16(d & 16'h0100, 16'h0100);
    rchk(dual_async_serial_pkg::CHAN2_DATA_PORT_OFS, 16'h66cc);
  endtask : t_data
  // queue mode closes the channel-one data port
  task t_queue;
    wr(dual_async_serial_pkg::QUEUE_CONTROL_OFS, 16'h0020);
    rchk(dual_async_serial_pkg::QUEUE_CONTROL_OFS, 16'h0020);
    wr(dual_async_serial_pkg::CHAN1_DATA_PORT_OFS, 16'h7777);
    #1 chk16({15'h0000, tx_load_o[0]}, 16'h0000);
    rchk(dual_async_serial_pkg::CHAN1_FLAGS_OFS, 16'h0180);
    rchk(dual_async_serial_pkg::CHAN1_DATA_PORT_OFS, 16'h0000);
    wr(dual_async_serial_pkg::TXQ_FIRST_OFS, 16'hbeef);
    wr(dual_async_serial_pkg::RXQ_LAST_OFS, 16'h1357);
    wr(16'hfc2d, 16'hffff);
    rchk(dual_async_serial_pkg::TXQ_FIRST_OFS, 16'hbeef);
    rchk(dual_async_serial_pkg::RXQ_LAST_OFS, 16'h1357);
    rchk(16'hfc2d, 16'h0000);
    wr(dual_async_serial_pkg::QUEUE_CONTROL_OFS, 16'h0000);
    wr(dual_async_serial_pkg::CHAN1_DATA_PORT_OFS, 16'h7777);
    #1 chk16({15'h0000, tx_load_o[0]}, 16'h0001);
    rchk(dual_async_serial_pkg::CHAN1_DATA_PORT_OFS, 16'h2d2d);
    rchk(dual_async_serial_pkg::CHAN1_FLAGS_OFS, 16'h0080);
    repeat (4) @(posedge clk_i);
    rchk(dual_async_serial_pkg::CHAN1_FLAGS_OFS, 16'h0180);
  endtask : t_queue

  initial begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_masks();
    t_enable();
    t_baud();
    t_data();
    t_queue();
    end_sim();
  end
endmodule : dual_async_serial_regs_baud_test
